// ===== design/wcm_chan_mgr.sv
// Purpose: Eight-channel slot scheduler with host command port and radio packet port.
// Assumes: Host holds cmd stable until cmd_ready; radio consumes tx_pkt while tx_valid is high.
// Notes: Slots are served one at a time, lowest channel first, with a bandwidth gap after each.
`timescale 1ns/1ps
// Operation
// RULE1: Up to eight independent logical channels are held and scheduled.
// RULE2: Each open channel gets a slot every period, 5.2 ms to 2 s.
// RULE3: Master transmits first in each slot; slave listens, aligns, then may reply.
// RULE4: Each slot moves 8 payload bytes as broadcast, acknowledged or burst.
// RULE5: Slots share a 20 kbps payload budget through enforced spacing.
// RULE6: Master without fresh host data resends its previous packet.
// RULE7: Each channel uses one of 78 radio frequencies.
// RULE8: Role is bidirectional slave, master, shared slave or receive-only slave.
// RULE9: Identity is transmission type, device type and 16-bit device number.
// RULE10: Packets carry identity; frequency, network and roles must match to link.
// RULE11: Network key of public, managed or private network gates linking.
// RULE12: After reset every channel sits on the public network.
// RULE13: Network selection is stored separately for every channel.
// RULE14: Role and settings are stored separately for every channel.
// RULE15: An open master sends its complete identity.
// RULE16: Host sets all identity fields before opening a master.
// RULE17: Host sets all identity fields to pin a slave to one master.
// RULE18: Slave treats zero identity fields as wildcards when matching.
// RULE19: Slave stores the learned identity fields for host read-back.
// RULE20: Air rate is 1 Mbps with 1 MHz channel spacing.
// RULE21: Opening a master with a wildcard identity is refused with an error.
module wcm_chan_mgr #(
  parameter int AIR_CYC = int'(wcm_pkg::AIR_CYC_DEF),
  parameter int GAP_CYC = int'(wcm_pkg::GAP_CYC_DEF),
  parameter int LISTEN_CYC = 2 * int'(wcm_pkg::AIR_CYC_DEF)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Host command and response.
  input wire logic cmd_valid,
  input wire wcm_pkg::wcm_cmd_s cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output wcm_pkg::wcm_rsp_s rsp,
  // Channel events.
  output logic evt_valid,
  output wcm_pkg::wcm_evt_s evt,
  // Network keys.
  input wire logic [wcm_pkg::KEY_W-1:0] key_managed,
  input wire logic [wcm_pkg::KEY_W-1:0] key_private,
  // Radio packet port.
  output logic tx_valid,
  output wcm_pkg::wcm_pkt_s tx_pkt,
  output logic rx_on,
  output logic [wcm_pkg::FREQ_W-1:0] rx_freq,
  input wire logic rx_valid,
  input wire wcm_pkg::wcm_pkt_s rx_pkt,
  // Channel status.
  output logic [wcm_pkg::NUM_CHAN-1:0] chan_open,
  output logic [wcm_pkg::NUM_CHAN-1:0] chan_linked
);
  import wcm_pkg::*;

  // Key for a network selection.
  function automatic logic [KEY_W-1:0] key_of(input wcm_net_e net, input logic [KEY_W-1:0] km,
                                               input logic [KEY_W-1:0] kp);
    case (net)
      NET_MANAGED: key_of = km;
      NET_PRIVATE: key_of = kp;
      default: key_of = PUBLIC_KEY;
    endcase
  endfunction : key_of

  // True when any identity field is a wildcard.
  function automatic logic id_wild(input wcm_id_s id);
    id_wild = (id.tx_type == WILD_BYTE) || (id.dev_type == WILD_BYTE) || (id.dev_num == WILD_NUM);
  endfunction : id_wild

  // Wildcard-aware identity comparison.
  function automatic logic id_match(input wcm_id_s want, input wcm_id_s got);
    id_match = ((want.tx_type == WILD_BYTE) || (want.tx_type == got.tx_type)) &&
               ((want.dev_type == WILD_BYTE) || (want.dev_type == got.dev_type)) &&
               ((want.dev_num == WILD_NUM) || (want.dev_num == got.dev_num));
  endfunction : id_match

  wcm_state_e state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CH_W-1:0] cur_ch_ff, nxt_cur_ch;
  wcm_cfg_s cur_cfg_ff, nxt_cur_cfg;
  wcm_op_e hop_ff, nxt_hop;
  logic reply_ff, nxt_reply;
  logic [NUM_CHAN-1:0] open_ff, nxt_open, linked_ff, nxt_linked, fresh_ff, nxt_fresh, due_ff, nxt_due;
  wcm_kind_e kind_ff [NUM_CHAN];
  wcm_kind_e nxt_kind [NUM_CHAN];
  logic [PER_W-1:0] period_ff [NUM_CHAN];
  logic [PER_W-1:0] nxt_period [NUM_CHAN];
  logic cmd_ready_ff, nxt_cmd_ready, rsp_valid_ff, nxt_rsp_valid, evt_valid_ff, nxt_evt_valid;
  logic tx_valid_ff, nxt_tx_valid, rx_on_ff, nxt_rx_on;
  wcm_rsp_s rsp_ff, nxt_rsp;
  wcm_evt_s evt_ff, nxt_evt;
  wcm_pkt_s tx_pkt_ff, nxt_tx_pkt;
  logic [NUM_CHAN-1:0] realign;
  logic cfg_we, pay_we;
  logic [CH_W-1:0] mem_waddr, mem_raddr;
  wcm_cfg_s cfg_wdata, cfg_q;
  logic [PAYLOAD_BITS-1:0] pay_wdata, pay_q;
  logic [TICK_W-1:0] tick_ff, nxt_tick;
  logic tick;
  logic [PER_W-1:0] timer_ff [NUM_CHAN];
  logic [PER_W-1:0] nxt_timer [NUM_CHAN];
  logic [NUM_CHAN-1:0] hit;
  logic [KEY_W-1:0] cur_key;
  logic rx_ok;

  // Per-channel configuration store, reset to the public network.
  wcm_mem #(.DW($bits(wcm_cfg_s)), .INIT(CFG_RESET)) u_cfg_mem ( // RULE12 RULE13 RULE14
    .clk(clk), .sys_rst(sys_rst), .we(cfg_we), .waddr(mem_waddr), .wdata(cfg_wdata),
    .raddr(mem_raddr), .rdata(cfg_q)
  );

  // Per-channel last payload; it stays until the host replaces it.
  wcm_mem #(.DW(PAYLOAD_BITS), .INIT('0)) u_pay_mem ( // RULE6
    .clk(clk), .sys_rst(sys_rst), .we(pay_we), .waddr(mem_waddr), .wdata(pay_wdata),
    .raddr(mem_raddr), .rdata(pay_q)
  );

  // Period timers advance on the 32768 Hz tick; a hit marks the channel due.
  assign tick = (tick_ff == TICK_W'(TICK_CYC - 1));
  always_comb begin
    nxt_tick = tick ? '0 : tick_ff + 1'b1;
    for (int i = 0; i < NUM_CHAN; i++) begin
      nxt_timer[i] = timer_ff[i];
      hit[i] = 1'b0;
      if (!open_ff[i]) begin
        nxt_timer[i] = '0;
      end else if (realign[i]) begin
        nxt_timer[i] = period_ff[i] - 1'b1; // RULE3
      end else if (tick) begin
        if (timer_ff[i] == '0) begin
          hit[i] = 1'b1; // RULE2
          nxt_timer[i] = period_ff[i] - 1'b1;
        end else begin
          nxt_timer[i] = timer_ff[i] - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    tick_ff <= sys_rst ? '0 : nxt_tick;
    for (int i = 0; i < NUM_CHAN; i++) begin
      timer_ff[i] <= sys_rst ? '0 : nxt_timer[i];
    end
  end

  // Receive qualification for the channel in its slot.
  assign cur_key = key_of(cur_cfg_ff.net, key_managed, key_private);
  assign rx_ok = rx_valid && (rx_pkt.freq == cur_cfg_ff.freq) && (rx_pkt.key == cur_key) && // RULE10 RULE11
                 ((cur_cfg_ff.role == ROLE_MST_BIDIR) ? (!rx_pkt.is_master && rx_pkt.id == cur_cfg_ff.id)
                                                      : (rx_pkt.is_master && id_match(cur_cfg_ff.id, rx_pkt.id))); // RULE18

  // Slot sequencer, host command handling and per-channel flags.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 1'b1;
    nxt_cur_ch = cur_ch_ff;
    nxt_cur_cfg = cur_cfg_ff;
    nxt_hop = hop_ff;
    nxt_reply = reply_ff;
    nxt_open = open_ff;
    nxt_linked = linked_ff;
    nxt_fresh = fresh_ff;
    nxt_due = due_ff | hit;
    nxt_kind = kind_ff;
    nxt_period = period_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp = rsp_ff;
    nxt_evt_valid = 1'b0;
    nxt_evt = evt_ff;
    nxt_tx_valid = tx_valid_ff;
    nxt_tx_pkt = tx_pkt_ff;
    nxt_rx_on = rx_on_ff;
    realign = '0;
    cfg_we = 1'b0;
    pay_we = 1'b0;
    mem_waddr = cur_ch_ff;
    mem_raddr = cur_ch_ff;
    cfg_wdata = cmd.cfg;
    pay_wdata = cmd.payload;
    case (state_ff)
      ST_IDLE: begin
        nxt_cnt = '0;
        if (cmd_valid && cmd_ready_ff) begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp = '{chan: cmd.chan, code: RSP_OK, id: '0};
          mem_waddr = cmd.chan;
          mem_raddr = cmd.chan;
          case (cmd.op)
            OP_CFG: begin
              if (open_ff[cmd.chan]) begin
                nxt_rsp.code = RSP_ERR_STATE;
              end else if (cmd.cfg.freq >= FREQ_W'(FREQ_COUNT) || cmd.cfg.period < PERIOD_MIN_TICKS ||
                           cmd.cfg.period > PERIOD_MAX_TICKS) begin
                nxt_rsp.code = RSP_ERR_RANGE; // RULE2 RULE7
              end else begin
                cfg_we = 1'b1; // RULE8 RULE9 RULE13 RULE14
              end
            end
            OP_DATA: begin
              pay_we = 1'b1; // RULE4
              nxt_fresh[cmd.chan] = 1'b1;
              nxt_kind[cmd.chan] = cmd.kind;
            end
            OP_CLOSE: begin
              nxt_open[cmd.chan] = 1'b0;
              nxt_linked[cmd.chan] = 1'b0;
              nxt_due[cmd.chan] = 1'b0;
            end
            default: begin
              nxt_rsp_valid = 1'b0;
              nxt_hop = cmd.op;
              nxt_cur_ch = cmd.chan;
              nxt_state = ST_HOST;
            end
          endcase
        end else if (due_ff != '0) begin
          for (int i = NUM_CHAN - 1; i >= 0; i--) begin
            if (due_ff[i]) begin
              nxt_cur_ch = CH_W'(i); // RULE1 RULE5
            end
          end
          mem_raddr = nxt_cur_ch;
          nxt_due[nxt_cur_ch] = hit[nxt_cur_ch];
          nxt_state = ST_FETCH;
        end
      end
      ST_HOST: begin
        nxt_rsp_valid = 1'b1;
        nxt_rsp = '{chan: cur_ch_ff, code: RSP_OK, id: cfg_q.id}; // RULE19
        if (hop_ff == OP_OPEN) begin
          if (open_ff[cur_ch_ff]) begin
            nxt_rsp.code = RSP_ERR_STATE;
          end else if (cfg_q.role == ROLE_MST_BIDIR && id_wild(cfg_q.id)) begin
            nxt_rsp.code = RSP_ERR_WILD; // RULE21 RULE16
          end else begin
            nxt_open[cur_ch_ff] = 1'b1;
            nxt_period[cur_ch_ff] = cfg_q.period;
          end
        end
        nxt_state = ST_IDLE;
      end
      ST_FETCH: begin
        nxt_cur_cfg = cfg_q;
        nxt_cnt = '0;
        nxt_tx_pkt = '{is_master: 1'b0, kind: KIND_BCAST, freq: cfg_q.freq,
                       key: key_of(cfg_q.net, key_managed, key_private), id: cfg_q.id, payload: pay_q};
        if (cfg_q.role == ROLE_MST_BIDIR) begin
          nxt_tx_pkt.is_master = 1'b1; // RULE3 RULE15
          nxt_tx_pkt.kind = kind_ff[cur_ch_ff];
          nxt_tx_valid = 1'b1; // RULE6
          nxt_state = ST_TX;
        end else begin
          nxt_rx_on = 1'b1;
          nxt_state = ST_LISTEN;
        end
      end
      ST_TX: begin
        if (cnt_ff == CNT_W'(AIR_CYC - 1)) begin
          nxt_cnt = '0;
          nxt_tx_valid = 1'b0; // RULE20
          nxt_evt_valid = 1'b1;
          nxt_evt = '{chan: cur_ch_ff, code: EVT_TX_DONE, payload: tx_pkt_ff.payload};
          nxt_fresh[cur_ch_ff] = 1'b0;
          if (tx_pkt_ff.is_master) begin
            nxt_due[cur_ch_ff] = hit[cur_ch_ff] | (tx_pkt_ff.kind == KIND_BURST && fresh_ff[cur_ch_ff]); // RULE4
            nxt_rx_on = 1'b1;
            nxt_state = ST_LISTEN;
          end else begin
            nxt_state = ST_GAP;
          end
        end
      end
      ST_LISTEN: begin
        if (rx_ok) begin
          nxt_rx_on = 1'b0;
          nxt_cnt = '0;
          nxt_evt_valid = 1'b1;
          nxt_evt = '{chan: cur_ch_ff, code: EVT_RX_DATA, payload: rx_pkt.payload};
          nxt_state = ST_GAP;
          if (cur_cfg_ff.role == ROLE_MST_BIDIR) begin
            if (tx_pkt_ff.kind == KIND_ACKED) begin
              nxt_evt.code = EVT_ACK_OK;
            end
          end else begin
            realign[cur_ch_ff] = 1'b1; // RULE3
            nxt_linked[cur_ch_ff] = 1'b1;
            if (!linked_ff[cur_ch_ff]) begin
              nxt_evt.code = EVT_LINKED;
            end
            nxt_cur_cfg.id = rx_pkt.id;
            cfg_we = id_wild(cur_cfg_ff.id); // RULE19
            cfg_wdata = nxt_cur_cfg;
            nxt_reply = (cur_cfg_ff.role == ROLE_SLV_BIDIR ||
                         (cur_cfg_ff.role == ROLE_SLV_SHARED && rx_pkt.payload[7:0] == rx_pkt.id.dev_num[7:0])) &&
                        (fresh_ff[cur_ch_ff] || rx_pkt.kind == KIND_ACKED); // RULE8
            if (nxt_reply) begin
              nxt_tx_pkt.id = rx_pkt.id;
              nxt_tx_pkt.kind = fresh_ff[cur_ch_ff] ? kind_ff[cur_ch_ff] : KIND_ACKED;
              nxt_tx_valid = 1'b1;
              nxt_state = ST_TX;
            end
          end
        end else if (cnt_ff == CNT_W'(LISTEN_CYC - 1)) begin
          nxt_rx_on = 1'b0;
          nxt_cnt = '0;
          nxt_state = ST_GAP;
          if (cur_cfg_ff.role == ROLE_MST_BIDIR && tx_pkt_ff.kind == KIND_ACKED) begin
            nxt_evt_valid = 1'b1;
            nxt_evt = '{chan: cur_ch_ff, code: EVT_ACK_FAIL, payload: tx_pkt_ff.payload};
          end
        end
      end
      ST_GAP: begin
        if (cnt_ff == CNT_W'(GAP_CYC - 1)) begin
          nxt_state = ST_IDLE; // RULE5
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    nxt_cmd_ready = (nxt_state == ST_IDLE) && !(cmd_valid && cmd_ready_ff);
  end

  always_ff @(posedge clk) begin
    state_ff <= sys_rst ? ST_IDLE : nxt_state;
    cnt_ff <= sys_rst ? '0 : nxt_cnt;
    cur_ch_ff <= sys_rst ? '0 : nxt_cur_ch;
    cur_cfg_ff <= sys_rst ? CFG_RESET : nxt_cur_cfg;
    hop_ff <= sys_rst ? OP_CFG : nxt_hop;
    reply_ff <= sys_rst ? 1'b0 : nxt_reply;
    open_ff <= sys_rst ? '0 : nxt_open;
    linked_ff <= sys_rst ? '0 : nxt_linked;
    fresh_ff <= sys_rst ? '0 : nxt_fresh;
    due_ff <= sys_rst ? '0 : nxt_due;
    for (int i = 0; i < NUM_CHAN; i++) begin
      kind_ff[i] <= sys_rst ? KIND_BCAST : nxt_kind[i];
      period_ff[i] <= sys_rst ? PERIOD_DEF_TICKS : nxt_period[i];
    end
    cmd_ready_ff <= sys_rst ? 1'b0 : nxt_cmd_ready;
    rsp_valid_ff <= sys_rst ? 1'b0 : nxt_rsp_valid;
    rsp_ff <= sys_rst ? '0 : nxt_rsp;
    evt_valid_ff <= sys_rst ? 1'b0 : nxt_evt_valid;
    evt_ff <= sys_rst ? '0 : nxt_evt;
    tx_valid_ff <= sys_rst ? 1'b0 : nxt_tx_valid;
    tx_pkt_ff <= sys_rst ? '0 : nxt_tx_pkt;
    rx_on_ff <= sys_rst ? 1'b0 : nxt_rx_on;
  end

  // Outputs straight from flip-flops.
  assign cmd_ready = cmd_ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp = rsp_ff;
  assign evt_valid = evt_valid_ff;
  assign evt = evt_ff;
  assign tx_valid = tx_valid_ff;
  assign tx_pkt = tx_pkt_ff;
  assign rx_on = rx_on_ff;
  assign rx_freq = cur_cfg_ff.freq;
  assign chan_open = open_ff;
  assign chan_linked = linked_ff;

  // Checks on the scheduler.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_wild_master_open: assert property ((state_ff == ST_HOST && hop_ff == OP_OPEN && !open_ff[cur_ch_ff] && // RULE21
      cfg_q.role == ROLE_MST_BIDIR && id_wild(cfg_q.id)) |=> rsp_valid_ff && rsp_ff.code == RSP_ERR_WILD &&
      !open_ff[rsp_ff.chan]) else $error("wildcard master open not refused");
  a_master_always_sends: assert property ((state_ff == ST_FETCH && cfg_q.role == ROLE_MST_BIDIR) |=> // RULE3
      tx_valid_ff && tx_pkt_ff.is_master && tx_pkt_ff.payload == $past(pay_q)) else $error("master slot silent");
  a_tx_full_id: assert property ($rose(tx_valid_ff) && tx_pkt_ff.is_master |-> // RULE15
      tx_pkt_ff.id == cur_cfg_ff.id && !id_wild(tx_pkt_ff.id)) else $error("master id incomplete");
  a_rxonly_silent: assert property (tx_valid_ff && !tx_pkt_ff.is_master |-> // RULE8
      cur_cfg_ff.role inside {ROLE_SLV_BIDIR, ROLE_SLV_SHARED}) else $error("receive-only slave transmitted");
  a_tx_freq_range: assert property (tx_valid_ff |-> tx_pkt_ff.freq < FREQ_W'(FREQ_COUNT)) // RULE7
      else $error("frequency out of range");
  a_period_range: assert property ($rose(open_ff[cur_ch_ff]) |-> period_ff[cur_ch_ff] >= PERIOD_MIN_TICKS && // RULE2
      period_ff[cur_ch_ff] <= PERIOD_MAX_TICKS) else $error("period out of range");
  a_gap_hold: assert property ($rose(state_ff == ST_GAP) |-> (state_ff == ST_GAP)[*8]) // RULE5
      else $error("slot spacing too short");
  a_tx_done_evt: assert property ($fell(tx_valid_ff) |-> evt_valid_ff && evt_ff.code == EVT_TX_DONE) // RULE4
      else $error("no done event after transmission");
  a_slave_link: assert property ((state_ff == ST_LISTEN && rx_ok && cur_cfg_ff.role != ROLE_MST_BIDIR) |=> // RULE18
      linked_ff[$past(cur_ch_ff)] && evt_valid_ff) else $error("matching master not linked");

endmodule : wcm_chan_mgr

// ===== pkg/wcm_pkg.sv
// Purpose: Shared constants and types of the wireless channel manager.
// Assumes: 50 MHz system clock; a zero identity field means wildcard.
// Notes: Long cycle counts are only defaults here; the top module exposes them as parameters.
package wcm_pkg;

  // Channel count and payload geometry.
  localparam int NUM_CHAN = 8;
  localparam int CH_W = 3;
  localparam int PAYLOAD_BYTES = 8;
  localparam int PAYLOAD_BITS = PAYLOAD_BYTES * 8;
  localparam int KEY_W = 64;

  // Radio band: 78 frequencies, 1 MHz apart, 1 Mbps on air.
  localparam int FREQ_COUNT = 78;
  localparam int FREQ_W = 7;
  localparam int RF_BASE_MHZ = 2400;
  localparam int RF_SPACING_MHZ = 1;
  localparam longint CLK_HZ = 50_000_000;
  localparam longint AIR_BPS = 1_000_000;
  localparam longint BIT_CYC = CLK_HZ / AIR_BPS;
  localparam int OVH_BITS = 64;
  localparam int PKT_BITS = PAYLOAD_BITS + OVH_BITS;
  localparam longint AIR_CYC_DEF = PKT_BITS * BIT_CYC;

  // Shared payload budget of 20 kbps sets the least spacing between slots.
  localparam longint BW_BPS = 20_000;
  localparam longint GAP_CYC_DEF = PAYLOAD_BITS * CLK_HZ / BW_BPS;

  // Channel period counted in 1/32768 s ticks, 5.2 ms to 2 s.
  localparam longint TICK_HZ = 32768;
  localparam int TICK_CYC = int'(CLK_HZ / TICK_HZ);
  localparam int TICK_W = 11;
  localparam longint PERIOD_MIN_US = 5200;
  localparam longint PERIOD_MAX_US = 2_000_000;
  localparam longint US_PER_S = 1_000_000;
  localparam int PER_W = 17;
  localparam logic [PER_W-1:0] PERIOD_MIN_TICKS = PER_W'((PERIOD_MIN_US * TICK_HZ + US_PER_S - 1) / US_PER_S);
  localparam logic [PER_W-1:0] PERIOD_MAX_TICKS = PER_W'(PERIOD_MAX_US * TICK_HZ / US_PER_S);
  localparam logic [PER_W-1:0] PERIOD_DEF_TICKS = 17'h02000;
  localparam int CNT_W = 18;

  // Identity wildcard values and the key of the open network.
  localparam logic [7:0] WILD_BYTE = 8'h00;
  localparam logic [15:0] WILD_NUM = 16'h0000;
  localparam logic [KEY_W-1:0] PUBLIC_KEY = 64'h0000_0000_0000_0000;
  localparam logic [FREQ_W-1:0] FREQ_DEF = 7'h00;

  typedef enum logic [1:0] {ROLE_SLV_BIDIR = 2'h0, ROLE_MST_BIDIR = 2'h1, ROLE_SLV_SHARED = 2'h2,
                            ROLE_SLV_RXONLY = 2'h3} wcm_role_e;
  typedef enum logic [1:0] {NET_PUBLIC = 2'h0, NET_MANAGED = 2'h1, NET_PRIVATE = 2'h2} wcm_net_e;
  typedef enum logic [1:0] {KIND_BCAST = 2'h0, KIND_ACKED = 2'h1, KIND_BURST = 2'h2} wcm_kind_e;
  typedef enum logic [2:0] {OP_CFG = 3'h0, OP_OPEN = 3'h1, OP_CLOSE = 3'h2, OP_DATA = 3'h3,
                            OP_READ_ID = 3'h4} wcm_op_e;
  typedef enum logic [1:0] {RSP_OK = 2'h0, RSP_ERR_WILD = 2'h1, RSP_ERR_STATE = 2'h2,
                            RSP_ERR_RANGE = 2'h3} wcm_rsp_e;
  typedef enum logic [2:0] {EVT_TX_DONE = 3'h0, EVT_RX_DATA = 3'h1, EVT_ACK_OK = 3'h2,
                            EVT_ACK_FAIL = 3'h3, EVT_LINKED = 3'h4} wcm_evt_e;
  typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_HOST = 3'h1, ST_FETCH = 3'h2, ST_TX = 3'h3,
                            ST_LISTEN = 3'h4, ST_GAP = 3'h5} wcm_state_e;

  typedef struct packed {
    logic [7:0] tx_type;
    logic [7:0] dev_type;
    logic [15:0] dev_num;
  } wcm_id_s;

  typedef struct packed {
    wcm_role_e role;
    wcm_net_e net;
    logic [FREQ_W-1:0] freq;
    logic [PER_W-1:0] period;
    wcm_id_s id;
  } wcm_cfg_s;

  typedef struct packed {
    wcm_op_e op;
    logic [CH_W-1:0] chan;
    wcm_cfg_s cfg;
    wcm_kind_e kind;
    logic [PAYLOAD_BITS-1:0] payload;
  } wcm_cmd_s;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    wcm_rsp_e code;
    wcm_id_s id;
  } wcm_rsp_s;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    wcm_evt_e code;
    logic [PAYLOAD_BITS-1:0] payload;
  } wcm_evt_s;

  typedef struct packed {
    logic is_master;
    wcm_kind_e kind;
    logic [FREQ_W-1:0] freq;
    logic [KEY_W-1:0] key;
    wcm_id_s id;
    logic [PAYLOAD_BITS-1:0] payload;
  } wcm_pkt_s;

  // Every channel leaves reset as a slave on the public network.
  localparam wcm_cfg_s CFG_RESET = '{role: ROLE_SLV_BIDIR, net: NET_PUBLIC, freq: FREQ_DEF,
                                     period: PERIOD_DEF_TICKS, id: '0};

endpackage : wcm_pkg

// ===== design/wcm_mem.sv
// Purpose: Small per-channel word store with a registered read port.
// Assumes: One write and one read per cycle; read data appear one edge after the address.
// Notes: Synchronous reset loads every word with INIT.
`timescale 1ns/1ps
module wcm_mem #(
  parameter int DW = 8,
  parameter logic [DW-1:0] INIT = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Write port.
  input wire logic we,
  input wire logic [wcm_pkg::CH_W-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port.
  input wire logic [wcm_pkg::CH_W-1:0] raddr,
  output logic [DW-1:0] rdata
);
  import wcm_pkg::*;

  logic [DW-1:0] mem_ff [NUM_CHAN];
  logic [DW-1:0] nxt_mem [NUM_CHAN];
  logic [DW-1:0] rdata_ff;
  logic [DW-1:0] nxt_rdata;

  // Next contents and the read word.
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      nxt_mem[i] = mem_ff[i];
    end
    if (we) begin
      nxt_mem[waddr] = wdata;
    end
    nxt_rdata = mem_ff[raddr];
  end

  // Registered store; reset brings every word to its default.
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      mem_ff[i] <= sys_rst ? INIT : nxt_mem[i];
    end
    rdata_ff <= sys_rst ? INIT : nxt_rdata;
  end

  assign rdata = rdata_ff;

endmodule : wcm_mem

// ===== dv/wcm_radio_peer.sv
// Purpose: Radio peer that answers each listen window with one packet.
// Assumes: The bench holds the packet that the peer sends.
// Notes: Outside the pulse the data lines carry the inverse packet.
`timescale 1ns/1ps
module wcm_radio_peer (
  // Clock.
  input wire logic clk,
  // Radio side.
  input wire logic rx_on,
  input wire wcm_pkg::wcm_pkt_s pkt,
  output logic rx_valid,
  output wcm_pkg::wcm_pkt_s rx_pkt
);
  import wcm_pkg::*;
  logic on_ff = 1'b0;
  // Pulses once, one cycle after a listen window opens.
  always_ff @(posedge clk) begin
    on_ff <= rx_on;
    rx_valid <= rx_on && !on_ff;
  end
  // Stale data never looks like a held packet.
  assign rx_pkt = rx_valid ? pkt : ~pkt;
endmodule : wcm_radio_peer

// ===== dv/tb_top.sv
// Purpose: Self-checking bench of the channel manager.
// Assumes: Shortened air, listen and gap counts.
// Notes: Responses are matched in order against a queue of notes.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; $display("CHECK FAILED %0t value mismatch", $time); end end
module tb_top;
  import wcm_pkg::*;
  logic clk = 0, sys_rst = 1, cmd_valid = 0, cmd_ready, rsp_valid, evt_valid, tx_valid, rx_on, rx_valid;
  wcm_cmd_s cmd = '0;
  wcm_rsp_s rsp, q[$];
  bit qm[$];
  wcm_evt_s evt;
  wcm_pkt_s tx_pkt, rx_pkt, peer = '0;
  logic [KEY_W-1:0] km = '0, kp = '0;
  logic [FREQ_W-1:0] rx_freq;
  logic [NUM_CHAN-1:0] chan_open, chan_linked;
  logic [31:0] seed = 32'h15D0EFBF;
  int n_mismatch = 0, total_checks = 0;
  wcm_id_s id1 = '{8'h05, 8'h11, 16'h1234};
  wcm_cfg_s c;
  always #10 clk = ~clk;
  wcm_chan_mgr #(.AIR_CYC(20), .GAP_CYC(10), .LISTEN_CYC(40)) DUT (.clk(clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .evt_valid(evt_valid), .evt(evt), .key_managed(km), .key_private(kp), .tx_valid(tx_valid),
    .tx_pkt(tx_pkt), .rx_on(rx_on), .rx_freq(rx_freq), .rx_valid(rx_valid), .rx_pkt(rx_pkt),
    .chan_open(chan_open), .chan_linked(chan_linked));
  wcm_radio_peer u_peer (.clk(clk), .rx_on(rx_on), .pkt(peer), .rx_valid(rx_valid), .rx_pkt(rx_pkt));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // Holds one command until taken and notes the response it should get.
  task automatic send(wcm_op_e op, logic [CH_W-1:0] ch, wcm_rsp_e ec, wcm_id_s eid, bit mi);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, chan: ch, cfg: c, kind: KIND_BCAST, payload: 64'h0};
    q.push_back('{chan: ch, code: ec, id: eid});
    qm.push_back(mi);
    @(negedge clk);
    for (int k = 0; k < 9999 && cmd_ready !== 1'b1; k++) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : send
  // Each response is matched against the oldest note.
  always @(negedge clk) begin
    if (rsp_valid === 1'b1 && q.size() == 0) `CHK(1'b0, 1'b1)
    if (rsp_valid === 1'b1 && q.size() > 0) begin
      `CHK(rsp.code, q[0].code)
      `CHK(rsp.chan, q[0].chan)
      if (qm[0]) `CHK(rsp.id, q[0].id)
      q.delete(0);
      qm.delete(0);
    end
  end
  // Main sequence.
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    seed = xs(seed);
    km <= {seed, ~seed};
    kp <= {~seed, seed};
    @(negedge clk);
    `CHK({chan_open, chan_linked}, 16'h0000)
    $display("test reset done");
    c = CFG_RESET;
    c.freq = 7'h4E;
    send(OP_CFG, 3'h2, RSP_ERR_RANGE, '0, 0);
    c.freq = 7'h4D;
    c.period = 17'h000AA;
    send(OP_CFG, 3'h2, RSP_ERR_RANGE, '0, 0);
    c.period = 17'h000AB;
    for (int r = 0; r < 4; r++) begin
      c.role = wcm_role_e'(r);
      send(OP_CFG, 3'(r + 4), RSP_OK, '0, 0);
    end
    $display("test ranges and roles done");
    c = CFG_RESET;
    c.role = ROLE_MST_BIDIR;
    c.freq = 7'h09;
    c.id = '{8'h00, 8'h11, 16'h1234};
    send(OP_CFG, 3'h1, RSP_OK, '0, 0);
    send(OP_OPEN, 3'h1, RSP_ERR_WILD, '0, 0);
    c.id = id1;
    send(OP_CFG, 3'h1, RSP_OK, '0, 0);
    send(OP_OPEN, 3'h1, RSP_OK, '0, 0);
    send(OP_OPEN, 3'h1, RSP_ERR_STATE, '0, 0);
    send(OP_CFG, 3'h1, RSP_ERR_STATE, '0, 0);
    for (int k = 0; k < 9999 && tx_valid !== 1'b1; k++) @(negedge clk);
    `CHK({tx_pkt.is_master, tx_pkt.freq, tx_pkt.key, tx_pkt.id}, {1'b1, 7'h09, PUBLIC_KEY, id1})
    for (int k = 0; k < 9999 && evt_valid !== 1'b1; k++) @(negedge clk);
    `CHK({evt.code, evt.chan}, {EVT_TX_DONE, 3'h1})
    $display("test master open done");
    @(posedge clk);
    seed = xs(seed);
    peer <= '{is_master: 1'b1, kind: KIND_BCAST, freq: 7'h05, key: PUBLIC_KEY,
      id: '{8'h07, 8'h22, seed[15:0] | 16'h0001}, payload: {2{seed}}};
    c = CFG_RESET;
    c.freq = 7'h05;
    c.id = '{8'h07, 8'h22, 16'h0000};
    send(OP_CFG, 3'h0, RSP_OK, '0, 0);
    send(OP_DATA, 3'h0, RSP_OK, '0, 0);
    send(OP_OPEN, 3'h0, RSP_OK, '0, 0);
    for (int k = 0; k < 9999 && chan_linked[0] !== 1'b1; k++) @(negedge clk);
    `CHK({evt_valid, evt.code, evt.chan, rx_freq}, {1'b1, EVT_LINKED, 3'h0, 7'h05})
    `CHK(evt.payload, peer.payload)
    `CHK({tx_valid, tx_pkt.is_master, tx_pkt.id}, {1'b1, 1'b0, peer.id})
    `CHK({chan_open[1:0], chan_linked[0]}, 3'b111)
    send(OP_READ_ID, 3'h0, RSP_OK, peer.id, 1);
    $display("test slave search done");
    repeat (50) @(posedge clk);
    `CHK(q.size(), 0)
    print_verdict();
  end
  // Cuts a hang short well past the expected run.
  initial begin
    #1500000;
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_top
